// ---- rtl/csr_regs.v ----
// Function
// - Unimplemented bits of both registers read as zero and ignore writes.
// - Half carry is set by a carry out of bit 3 (byte) or bit 7 (word), else cleared.
// - The three-bit priority field encodes level 0 to 7 in binary and all flags reset to zero.
// - While nesting_disable is high, software writes to the three priority bits are ignored.
// - The high priority bit joins above the three status bits to give a four-bit level.
// - The repeat-loop active bit follows the hardware loop and is read-only to software.
// - The negative flag copies the sign of the result of an affecting operation.
// - The overflow flag is set on signed overflow and cleared otherwise.
// - The zero flag is set by a zero result and cleared by a non-zero result.
// - The carry flag is set by a carry out of the top bit and cleared otherwise.
// - The high priority bit is set by hardware and may only be cleared by software.
// - While the high priority bit is set, all user interrupts are blocked.
// - The program space window enable bit shows or hides the window and resets to zero.
// - Flags are writable by software and later overwritten by hardware updates.
// - For subtraction carry and half carry mean not-borrow and not-digit-borrow.
`timescale 1ns/1ps
`default_nettype none
`include "csr_defs.vh"

module csr_regs #(
   parameter W = 16
) (
   input wire clk,
   input wire arst_n,
   input wire clk_en,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   input wire [W-1:0] alu_op_a,
   input wire [W-1:0] alu_op_b,
   input wire alu_is_sub,
   input wire alu_is_byte,
   input wire alu_valid,
   input wire [4:0] alu_flag_en,
   input wire repeat_loop_active,
   input wire nesting_disable,
   input wire pri_load,
   input wire [3:0] pri_value,
   output reg [3:0] cpu_priority_level,
   output reg user_irq_block,
   output reg program_space_window_enable
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   reg half_carry_flag_ff;
   reg [2:0] pri_lo_ff;
   reg ra_ff;
   reg n_ff;
   reg ov_ff;
   reg z_ff;
   reg c_ff;
   reg pri_hi_ff;
   reg psv_ff;
   reg nxt_dc;
   reg [2:0] nxt_pri_lo;
   reg nxt_n;
   reg nxt_ov;
   reg nxt_z;
   reg nxt_c;
   reg nxt_pri_hi;
   reg nxt_psv;
   reg [15:0] nxt_rdata;
   wire f_c;
   wire f_dc;
   wire f_n;
   wire f_ov;
   wire f_z;
   wire [3:0] nxt_level;

   function sel;
      input [3:0] a;
      input [3:0] idx;
      begin
         sel = (a == idx);
      end
   endfunction

   function blocks_user;
      input [3:0] lvl;
      begin
         blocks_user = (lvl >= `CSR_PRI_USER_MAX);
      end
   endfunction

   // ----------------------------------------
   // Flag calculator
   // ----------------------------------------
   csr_flag_calc #(.W(W)) u_calc (
      .op_a(alu_op_a),
      .op_b(alu_op_b),
      .is_sub(alu_is_sub),
      .is_byte(alu_is_byte),
      .flag_c(f_c),
      .flag_dc(f_dc),
      .flag_n(f_n),
      .flag_ov(f_ov),
      .flag_z(f_z)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   wire wr_st = reg_wr && sel(reg_addr, `CSR_ADDR_STATUS);
   wire wr_ct = reg_wr && sel(reg_addr, `CSR_ADDR_CONTROL);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @* begin
      nxt_dc = half_carry_flag_ff;
      nxt_pri_lo = pri_lo_ff;
      nxt_n = n_ff;
      nxt_ov = ov_ff;
      nxt_z = z_ff;
      nxt_c = c_ff;
      nxt_pri_hi = pri_hi_ff;
      nxt_psv = psv_ff;
      // Software writes first; only implemented bits are taken
      if (wr_st) begin
         nxt_dc = reg_wdata[`CSR_ST_DC];
         nxt_n = reg_wdata[`CSR_ST_N];
         nxt_ov = reg_wdata[`CSR_ST_OV];
         nxt_z = reg_wdata[`CSR_ST_Z];
         nxt_c = reg_wdata[`CSR_ST_C];
         if (!nesting_disable) begin
            nxt_pri_lo = reg_wdata[`CSR_ST_PRI_HI:`CSR_ST_PRI_LO];
         end
      end
      if (wr_ct) begin
         nxt_psv = reg_wdata[`CSR_CT_PSV];
         if (!reg_wdata[`CSR_CT_PRI3]) begin
            nxt_pri_hi = 1'b0;
         end
      end
      // Hardware updates override software in the same cycle
      if (alu_valid) begin
         if (alu_flag_en[0]) begin
            nxt_c = f_c;
         end
         if (alu_flag_en[1]) begin
            nxt_z = f_z;
         end
         if (alu_flag_en[2]) begin
            nxt_ov = f_ov;
         end
         if (alu_flag_en[3]) begin
            nxt_n = f_n;
         end
         if (alu_flag_en[4]) begin
            nxt_dc = f_dc;
         end
      end
      if (pri_load) begin
         nxt_pri_lo = pri_value[2:0];
         nxt_pri_hi = pri_value[3];
      end
   end

   // ----------------------------------------
   // Priority level
   // ----------------------------------------
   assign nxt_level = {nxt_pri_hi, nxt_pri_lo};

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   wire rd_st = reg_rd && sel(reg_addr, `CSR_ADDR_STATUS);
   wire rd_ct = reg_rd && sel(reg_addr, `CSR_ADDR_CONTROL);
   wire [15:0] rd_mask = rd_st ? `CSR_STATUS_MASK : (rd_ct ? `CSR_CONTROL_MASK : 16'h0000);

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always @* begin
      nxt_rdata = 16'h0000;
      if (reg_rd) begin
         if (sel(reg_addr, `CSR_ADDR_STATUS)) begin
            nxt_rdata[`CSR_ST_DC] = half_carry_flag_ff;
            nxt_rdata[`CSR_ST_PRI_HI:`CSR_ST_PRI_LO] = pri_lo_ff;
            nxt_rdata[`CSR_ST_RA] = ra_ff;
            nxt_rdata[`CSR_ST_N] = n_ff;
            nxt_rdata[`CSR_ST_OV] = ov_ff;
            nxt_rdata[`CSR_ST_Z] = z_ff;
            nxt_rdata[`CSR_ST_C] = c_ff;
         end else if (sel(reg_addr, `CSR_ADDR_CONTROL)) begin
            nxt_rdata[`CSR_CT_PRI3] = pri_hi_ff;
            nxt_rdata[`CSR_CT_PSV] = psv_ff;
         end
      end
   end

   // ----------------------------------------
   // Carry flag
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         c_ff <= 1'b0;
      end else if (clk_en) begin
         c_ff <= nxt_c;
      end
   end

   // ----------------------------------------
   // Zero flag
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         z_ff <= 1'b0;
      end else if (clk_en) begin
         z_ff <= nxt_z;
      end
   end

   // ----------------------------------------
   // Overflow flag
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ov_ff <= 1'b0;
      end else if (clk_en) begin
         ov_ff <= nxt_ov;
      end
   end

   // ----------------------------------------
   // Negative flag
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         n_ff <= 1'b0;
      end else if (clk_en) begin
         n_ff <= nxt_n;
      end
   end

   // ----------------------------------------
   // Half carry flag
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         half_carry_flag_ff <= 1'b0;
      end else if (clk_en) begin
         half_carry_flag_ff <= nxt_dc;
      end
   end

   // ----------------------------------------
   // Repeat loop flag
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ra_ff <= 1'b0;
      end else if (clk_en) begin
         ra_ff <= repeat_loop_active;
      end
   end

   // ----------------------------------------
   // Low priority bits
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pri_lo_ff <= 3'h0;
      end else if (clk_en) begin
         pri_lo_ff <= nxt_pri_lo;
      end
   end

   // ----------------------------------------
   // High priority bit
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pri_hi_ff <= 1'b0;
      end else if (clk_en) begin
         pri_hi_ff <= nxt_pri_hi;
      end
   end

   // ----------------------------------------
   // Window enable bit
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         psv_ff <= 1'b0;
      end else if (clk_en) begin
         psv_ff <= nxt_psv;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en) begin
         reg_rdata <= nxt_rdata & rd_mask;
      end
   end

   // ----------------------------------------
   // Priority level output
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_priority_level <= 4'h0;
      end else if (clk_en) begin
         cpu_priority_level <= nxt_level;
      end
   end

   // ----------------------------------------
   // Interrupt block output
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         user_irq_block <= 1'b0;
      end else if (clk_en) begin
         user_irq_block <= blocks_user(nxt_level);
      end
   end

   // ----------------------------------------
   // Window enable output
   // ----------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         program_space_window_enable <= 1'b0;
      end else if (clk_en) begin
         program_space_window_enable <= nxt_psv;
      end
   end
endmodule

`default_nettype wire

// ---- rtl/csr_defs.vh ----
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// ----------------------------------------
// Register indices (word addresses)
// ----------------------------------------
`define CSR_ADDR_STATUS 4'h0
`define CSR_ADDR_CONTROL 4'h1

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define CSR_ST_C 0
`define CSR_ST_Z 1
`define CSR_ST_OV 2
`define CSR_ST_N 3
`define CSR_ST_RA 4
`define CSR_ST_PRI_LO 5
`define CSR_ST_PRI_HI 7
`define CSR_ST_DC 8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CSR_CT_PSV 2
`define CSR_CT_PRI3 3

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CSR_STATUS_RST 16'h0000
`define CSR_CONTROL_RST 16'h0000
`define CSR_STATUS_MASK 16'h01FF
`define CSR_CONTROL_MASK 16'h000C
`define CSR_PRI_USER_MAX 4'h7

`endif

// ---- rtl/csr_flag_calc.v ----
`timescale 1ns/1ps
`default_nettype none
`include "csr_defs.vh"

// ----------------------------------------
// Flag calculation from an ALU result
// ----------------------------------------
module csr_flag_calc #(
   parameter W = 16
) (
   input wire [W-1:0] op_a,
   input wire [W-1:0] op_b,
   input wire is_sub,
   input wire is_byte,
   output reg flag_c,
   output reg flag_dc,
   output reg flag_n,
   output reg flag_ov,
   output reg flag_z
);
   reg [W:0] sum;
   reg [W-1:0] bx;
   reg [8:0] lo8;
   reg [4:0] lo4;
   reg [8:0] by;
   always @* begin
      bx = is_sub ? ~op_b : op_b;
      sum = {1'b0, op_a} + {1'b0, bx} + {{W{1'b0}}, is_sub};
      lo4 = {1'b0, op_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, is_sub};
      lo8 = {1'b0, op_a[7:0]} + {1'b0, bx[7:0]} + {8'h00, is_sub};
      by = lo8;
      // Carry set means no borrow for subtraction
      if (is_byte) begin
         flag_c = by[8];
         flag_dc = lo4[4];
         flag_n = by[7];
         flag_ov = (op_a[7] == bx[7]) && (by[7] != op_a[7]);
         flag_z = (by[7:0] == 8'h00);
      end else begin
         flag_c = sum[W];
         flag_dc = lo8[8];
         flag_n = sum[W-1];
         flag_ov = (op_a[W-1] == bx[W-1]) && (sum[W-1] != op_a[W-1]);
         flag_z = (sum[W-1:0] == {W{1'b0}});
      end
   end
endmodule

`default_nettype wire

// ---- sim/csr_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module csr_regs_chk (
   input wire clk,
   input wire arst_n,
   input wire clk_en,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire alu_valid,
   input wire repeat_loop_active,
   input wire nesting_disable,
   input wire pri_load,
   input wire [3:0] cpu_priority_level,
   input wire user_irq_block
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   rd_idle_zero_a:
      assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not cleared");
   stat_hi_zero_a:
      assert property (reg_rdata[15:9] == 7'h00) else $error("upper bits not zero");
   ctrl_unused_a:
      assert property (clk_en && reg_rd && reg_addr == 4'h1 |=> reg_rdata[15:4] == 12'h000 && reg_rdata[1:0] == 2'h0)
      else $error("control unused bits set");
   unmapped_zero_a:
      assert property (clk_en && reg_rd && reg_addr > 4'h1 |=> reg_rdata == 16'h0000) else $error("unmapped read");
   loop_flag_a:
      assert property (clk_en && $past(clk_en) && $past(arst_n) && reg_rd && reg_addr == 4'h0
         |=> reg_rdata[4] == $past(repeat_loop_active, 2)) else $error("loop flag wrong");
   irq_block_a:
      assert property (user_irq_block == (cpu_priority_level >= 4'h7)) else $error("block level mismatch");
   freeze_a:
      assert property (!clk_en |=> $stable(reg_rdata) && $stable(cpu_priority_level)) else $error("not frozen");
   wr_rd_a:
      assert property (clk_en && reg_wr && reg_addr == 4'h0 && !alu_valid && !pri_load && !nesting_disable
         ##1 clk_en && reg_rd && reg_addr == 4'h0 |=> reg_rdata[8:5] == $past(reg_wdata[8:5], 2)
         && reg_rdata[3:0] == $past(reg_wdata[3:0], 2)) else $error("written flags lost");
endmodule

bind csr_regs csr_regs_chk u_chk (.clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .alu_valid, .repeat_loop_active, .nesting_disable, .pri_load, .cpu_priority_level, .user_irq_block);
`default_nettype wire

// ---- sim/cpu_status_control_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_status_control_regs_tb;
   logic clk = 0, arst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, alu_is_sub = 0, alu_is_byte = 0, s, y;
   logic alu_valid = 0, repeat_loop_active = 0, nesting_disable = 0, pri_load = 0, user_irq_block;
   logic program_space_window_enable;
   logic [3:0] reg_addr = 0, pri_value = 0, cpu_priority_level;
   logic [4:0] alu_flag_en = 0, en;
   logic [15:0] reg_wdata = 0, alu_op_a = 0, alu_op_b = 0, reg_rdata, a, b, st = 0, m;
   integer errors = 0, num_checks = 0, cycles = 0, seed = 94, i;
   wire [15:0] outs = {10'h000, program_space_window_enable, user_irq_block, cpu_priority_level};
   always #12.5 clk = ~clk;
   csr_regs u_csr_regs (.clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alu_op_a,
      .alu_op_b, .alu_is_sub, .alu_is_byte, .alu_valid, .alu_flag_en, .repeat_loop_active, .nesting_disable,
      .pri_load, .pri_value, .cpu_priority_level, .user_irq_block, .program_space_window_enable);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task end_sim;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         end_sim;
      end
   end
   task chk(input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task wr(input logic [3:0] ad, input logic [15:0] d);
      reg_wr <= 1; reg_addr <= ad; reg_wdata <= d;
      @(posedge clk); reg_wr <= 0;
   endtask
   task rd(input logic [3:0] ad, input logic [15:0] e);
      reg_rd <= 1; reg_addr <= ad;
      @(posedge clk); reg_rd <= 0;
      @(negedge clk); chk(e, reg_rdata);
      @(posedge clk);
   endtask
   task alu(input logic [15:0] x, input logic [15:0] z, input logic sb, input logic by, input logic [4:0] en);
      alu_valid <= 1; alu_op_a <= x; alu_op_b <= z; alu_is_sub <= sb; alu_is_byte <= by; alu_flag_en <= en;
      @(posedge clk); alu_valid <= 0;
   endtask
   function logic [15:0] flags(input logic [15:0] x, input logic [15:0] z, input logic sb, input logic by);
      logic [15:0] zz; logic [16:0] r; logic [8:0] lo; logic [4:0] nb;
      zz = sb ? ~z : z;
      r = x + zz + sb;
      lo = x[7:0] + zz[7:0] + sb;
      nb = x[3:0] + zz[3:0] + sb;
      if (by) return {7'h00, nb[4], 4'h0, lo[7], x[7] == zz[7] && lo[7] != x[7], lo[7:0] == 8'h00, lo[8]};
      return {7'h00, lo[8], 4'h0, r[15], x[15] == zz[15] && r[15] != x[15], r[15:0] == 16'h0000, r[16]};
   endfunction
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1;
      rd(0, 16'h0000);
      rd(1, 16'h0000);
      for (i = 0; i < 40; i++) begin
         a = (i == 0) ? 16'h7FFF : (i < 3) ? 16'h0000 : 16'($random(seed));
         b = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0000 : (i == 2) ? 16'h0001 : 16'($random(seed));
         s = (i == 1 || i == 2) ? 1'b1 : (i == 0) ? 1'b0 : 1'($random(seed));
         y = (i < 3) ? 1'b0 : 1'($random(seed));
         en = (i < 20) ? 5'h1F : 5'($random(seed));
         m = {7'h00, en[4], 4'h0, en[3:0]};
         st = (flags(a, b, s, y) & m) | (st & ~m);
         alu(a, b, s, y, en);
         rd(0, st);
      end
      wr(0, 16'h010F);
      alu(16'h0000, 16'h0000, 1'b0, 1'b0, 5'h00);
      rd(0, 16'h010F);
      fork
         wr(0, 16'h0000);
         alu(16'hFFFF, 16'h0001, 1'b0, 1'b0, 5'h1F);
      join
      rd(0, 16'h0103);
      wr(0, 16'hFFFF);
      rd(0, 16'h01EF);
      wr(1, 16'hFFFF);
      rd(1, 16'h0004);
      wr(2, 16'hFFFF);
      rd(2, 16'h0000);
      nesting_disable <= 1;
      wr(0, 16'h0000);
      rd(0, 16'h00E0);
      nesting_disable <= 0;
      chk(16'h0037, outs);
      pri_load <= 1; pri_value <= 4'hA;
      @(posedge clk); pri_load <= 0;
      rd(1, 16'h000C);
      rd(0, 16'h0040);
      chk(16'h003A, outs);
      wr(1, 16'h0000);
      rd(1, 16'h0000);
      chk(16'h0002, outs);
      repeat_loop_active <= 1;
      @(posedge clk);
      rd(0, 16'h0050);
      clk_en <= 0;
      wr(0, 16'h0000);
      clk_en <= 1; repeat_loop_active <= 0;
      rd(0, 16'h0050);
      rd(0, 16'h0040);
      end_sim;
   end
endmodule
`default_nettype wire
